// file: verilog/cci_pkg.sv
/*
  Shared constants of the codec control-port link: register map, byte slots,
  host operations, host register map and serial clock timing.
  Assumes a 200 MHz system clock on both ends.
*/
package cci_pkg;
  localparam int          CCI_REG_N   = 32;
  localparam int          CCI_REG_AW  = 5;
  localparam logic [6:0]  CCI_DEV_ID  = 7'h1d; // Arbitrary value.
  localparam logic [14:0] CCI_CFG_ADDR = 15'h0014;
  localparam logic [4:0]  CCI_CFG_IDX = 5'h14;
  localparam logic [15:0] CCI_CFG_RST = 16'h0002;
  localparam int          CCI_CFG_AUTOINC = 0;
  localparam int          CCI_CFG_FOUR    = 1;
  localparam int          CCI_CFG_OD      = 2;
  localparam int          CCI_CFG_LATCH   = 3;
  // Byte slots of a two-wire transfer.
  localparam logic [2:0]  CCI_IDX_DEV = 3'h0;
  localparam logic [2:0]  CCI_IDX_AHI = 3'h1;
  localparam logic [2:0]  CCI_IDX_ALO = 3'h2;
  localparam logic [2:0]  CCI_IDX_DHI = 3'h3;
  localparam logic [2:0]  CCI_IDX_DLO = 3'h4;
  localparam logic [2:0]  CCI_LAST_BIT = 3'h7;
  localparam logic [3:0]  CCI_SLOT_BITS = 4'h8;
  // Host operations.
  localparam logic [1:0]  CCI_OP_WRITE     = 2'h0;
  localparam logic [1:0]  CCI_OP_READ      = 2'h1;
  localparam logic [1:0]  CCI_OP_READ_LAST = 2'h2;
  // Host line actions.
  localparam logic [3:0]  CCI_A_START   = 4'h0;
  localparam logic [3:0]  CCI_A_DEV_W   = 4'h1;
  localparam logic [3:0]  CCI_A_DEV_R   = 4'h2;
  localparam logic [3:0]  CCI_A_AHI     = 4'h3;
  localparam logic [3:0]  CCI_A_ALO     = 4'h4;
  localparam logic [3:0]  CCI_A_DHI     = 4'h5;
  localparam logic [3:0]  CCI_A_DLO     = 4'h6;
  localparam logic [3:0]  CCI_A_RX_ACK  = 4'h7;
  localparam logic [3:0]  CCI_A_RX_NACK = 4'h8;
  localparam logic [3:0]  CCI_A_STOP    = 4'h9;
  localparam logic [3:0]  CCI_STEP_ABORT = 4'hf;
  // Host register map, word indexes on the plain port.
  localparam logic [2:0]  CCI_H_CTRL   = 3'h0;
  localparam logic [2:0]  CCI_H_ADDR   = 3'h1;
  localparam logic [2:0]  CCI_H_WDATA  = 3'h2;
  localparam logic [2:0]  CCI_H_RDATA  = 3'h3;
  localparam logic [2:0]  CCI_H_STATUS = 3'h4;
  localparam int          CCI_ST_BUSY  = 0;
  localparam int          CCI_ST_NACK  = 1;
  // Serial clock timing.
  localparam int          CCI_CLK_PERIOD_NS = 5;
  localparam int          CCI_SCL_PERIOD_NS = 2500;
  localparam int          CCI_QUARTER_CYC = CCI_SCL_PERIOD_NS / (4 * CCI_CLK_PERIOD_NS);
  localparam logic [7:0]  CCI_QUARTER_LAST = 8'(CCI_QUARTER_CYC - 1);
endpackage

// file: verilog/cci_if.sv
/*
  Two-wire link between host and codec control port, plus strap and readback pin.
  Assumes the bench drives the strap; the pull-up on the data line is modelled here.
*/
`timescale 1ns/1ps
interface cci_if;
  logic scl;
  logic host_sda_o;
  logic host_sda_oe;
  logic dev_sda_o;
  logic dev_sda_oe;
  logic sda;
  logic strap;
  logic rb_o;
  logic rb_oe;
  // Open-drain data line with pull-up.
  assign sda = ~((host_sda_oe & ~host_sda_o) | (dev_sda_oe & ~dev_sda_o));
  modport device (input scl, input sda, input strap, output dev_sda_o, output dev_sda_oe, output rb_o, output rb_oe);
  modport host (output scl, output host_sda_o, output host_sda_oe, input sda);
endinterface

// file: verilog/cci_device.sv
/*
  Codec control-port slave: two-wire register access, strap mode selection,
  configuration register and a small register file.
  Assumes a 200 MHz clock well above the serial clock; link pins are asynchronous.
*/
`timescale 1ns/1ps
// Contract
// - Strap low picks two-wire, high serial mode.
// - Latch bit freezes mode, frees strap pin.
// - Fifteen-bit register address, sixteen-bit data.
// - Reads return current register contents.
// - Config bit 0 enables auto-increment.
// - Config bit 1 selects four-wire, resets one.
// - Config bit 2 selects open-drain readback.
// - Two-wire mode is slave, clock input only.
// - Data one sent by releasing line.
// - After start, shift eight bits MSB first.
// - Last address bit: one read, zero write.
// - Matching address acknowledged by pulling low.
// - Mismatch or forbidden read goes idle.
// - Stop ends transfer; device returns idle.
// - Stray start or stop abandons transfer.
// - Multi-word access only with auto-increment.
// - Auto-increment accesses consecutive addresses.
// - Read may start at last address.
module cci_device (
  // System
  input  wire logic        clock,
  input  wire logic        reset,
  // Link
  cci_if.device            link,
  // User side
  input  wire logic        soft_reset,
  input  wire logic        write_only,
  output logic             mode_two_wire,
  output logic             strap_free,
  output logic [15:0]      cfg_word,
  output logic             reg_wr_stb,
  output logic [14:0]      reg_wr_addr,
  output logic [15:0]      reg_wr_data
);
  typedef enum logic [4:0] {
    D_IDLE = 5'b00001,
    D_RX   = 5'b00010,
    D_ACK  = 5'b00100,
    D_TX   = 5'b01000,
    D_MACK = 5'b10000
  } cci_dst_e;

  typedef struct packed {
    logic [1:0]                               strap_sy;
    logic [1:0]                               scl_sy;
    logic [1:0]                               sda_sy;
    logic                                     scl_d;
    logic                                     sda_d;
    cci_dst_e                                 st;
    logic [2:0]                               bitcnt;
    logic [7:0]                               sh;
    logic [2:0]                               idx;
    logic                                     rw;
    logic                                     pend;
    logic                                     ack_ok;
    logic                                     more;
    logic [14:0]                              addr;
    logic [7:0]                               dhi;
    logic [15:0]                              tx;
    logic                                     sda_oe;
    logic                                     rb_oe;
    logic                                     spi_mode;
    logic                                     latched;
    logic                                     wr_stb;
    logic [14:0]                              wr_addr;
    logic [15:0]                              wr_data;
    logic [cci_pkg::CCI_REG_N-1:0][15:0]      regs;
  } cci_dev_s;

  cci_dev_s s_r;
  cci_dev_s s_nxt;

  function automatic logic cci_hit(input logic [14:0] a);
    cci_hit = a < 15'(cci_pkg::CCI_REG_N);
  endfunction

  function automatic logic [15:0] cci_rd(input logic [cci_pkg::CCI_REG_N-1:0][15:0] regs,
                                         input logic [14:0] a);
    cci_rd = cci_hit(a) ? regs[a[cci_pkg::CCI_REG_AW-1:0]] : 16'h0000;
  endfunction

  always_comb begin
    logic        rise;
    logic        fall;
    logic        start;
    logic        stop;
    logic        ok;
    logic [7:0]  b;
    logic [15:0] cfg;
    logic [15:0] wd;
    logic [14:0] nxt_a;
    rise  = s_r.scl_sy[1] & ~s_r.scl_d;
    fall  = ~s_r.scl_sy[1] & s_r.scl_d;
    start = s_r.scl_sy[1] & s_r.scl_d & s_r.sda_d & ~s_r.sda_sy[1];
    stop  = s_r.scl_sy[1] & s_r.scl_d & ~s_r.sda_d & s_r.sda_sy[1];
    ok    = 1'b0;
    b     = {s_r.sh[6:0], s_r.sda_sy[1]};
    cfg   = s_r.regs[cci_pkg::CCI_CFG_IDX];
    wd    = {s_r.dhi, b};
    nxt_a = s_r.addr + 15'h0001;

    s_nxt          = s_r;
    s_nxt.strap_sy = {s_r.strap_sy[0], link.strap};
    s_nxt.scl_sy   = {s_r.scl_sy[0], link.scl};
    s_nxt.sda_sy   = {s_r.sda_sy[0], link.sda};
    s_nxt.scl_d    = s_r.scl_sy[1];
    s_nxt.sda_d    = s_r.sda_sy[1];
    s_nxt.wr_stb   = 1'b0;
    if (!s_r.latched) begin
      s_nxt.spi_mode = s_r.strap_sy[1];
    end
    // Readback pin: push-pull drives low when idle, open drain stays released.
    s_nxt.rb_oe = s_r.spi_mode & cfg[cci_pkg::CCI_CFG_FOUR] & ~cfg[cci_pkg::CCI_CFG_OD];

    if (s_r.spi_mode) begin
      s_nxt.st     = D_IDLE;
      s_nxt.sda_oe = 1'b0;
    end else if (start) begin
      s_nxt.st     = D_RX;
      s_nxt.bitcnt = 3'h0;
      s_nxt.idx    = cci_pkg::CCI_IDX_DEV;
      s_nxt.pend   = 1'b0;
      s_nxt.more   = 1'b0;
      s_nxt.sda_oe = 1'b0;
    end else if (stop) begin
      s_nxt.st     = D_IDLE;
      s_nxt.sda_oe = 1'b0;
    end else begin
      case (s_r.st)
        D_RX: begin
          if (rise) begin
            s_nxt.sh     = b;
            s_nxt.bitcnt = s_r.bitcnt + 3'h1;
            if (s_r.bitcnt == cci_pkg::CCI_LAST_BIT) begin
              s_nxt.pend = 1'b1;
              case (s_r.idx)
                cci_pkg::CCI_IDX_DEV: begin
                  ok       = (b[7:1] == cci_pkg::CCI_DEV_ID) && !(b[0] && write_only);
                  s_nxt.rw = b[0];
                end
                cci_pkg::CCI_IDX_AHI: begin
                  ok         = 1'b1;
                  s_nxt.addr = 15'({b, s_r.addr[7:0]});
                end
                cci_pkg::CCI_IDX_ALO: begin
                  ok         = 1'b1;
                  s_nxt.addr = {s_r.addr[14:8], b};
                end
                cci_pkg::CCI_IDX_DHI: begin
                  ok        = !s_r.more || cfg[cci_pkg::CCI_CFG_AUTOINC];
                  s_nxt.dhi = b;
                  if (s_r.more) begin
                    s_nxt.addr = nxt_a;
                  end
                end
                cci_pkg::CCI_IDX_DLO: begin
                  ok            = 1'b1;
                  s_nxt.more    = 1'b1;
                  s_nxt.wr_stb  = 1'b1;
                  s_nxt.wr_addr = s_r.addr;
                  s_nxt.wr_data = wd;
                  if (cci_hit(s_r.addr)) begin
                    s_nxt.regs[s_r.addr[cci_pkg::CCI_REG_AW-1:0]] = wd;
                  end
                  if (s_r.addr == cci_pkg::CCI_CFG_ADDR) begin
                    s_nxt.latched = s_r.latched | wd[cci_pkg::CCI_CFG_LATCH];
                    s_nxt.regs[cci_pkg::CCI_CFG_IDX][cci_pkg::CCI_CFG_LATCH] =
                      s_r.latched | wd[cci_pkg::CCI_CFG_LATCH];
                  end
                end
                default: ok = 1'b0;
              endcase
              s_nxt.ack_ok = ok;
            end
          end else if (fall && s_r.pend) begin
            s_nxt.pend = 1'b0;
            if (s_r.ack_ok) begin
              s_nxt.st     = D_ACK;
              s_nxt.sda_oe = 1'b1;
              s_nxt.idx    = (s_r.idx == cci_pkg::CCI_IDX_DLO) ? cci_pkg::CCI_IDX_DHI : s_r.idx + 3'h1;
            end else begin
              s_nxt.st = D_IDLE;
            end
          end
        end
        D_ACK: begin
          if (fall) begin
            s_nxt.bitcnt = 3'h0;
            if (s_r.rw) begin
              // Reads start at the held address, so a bare read repeats the last one.
              s_nxt.st     = D_TX;
              s_nxt.idx    = cci_pkg::CCI_IDX_DHI;
              s_nxt.tx     = cci_rd(s_r.regs, s_r.addr);
              s_nxt.sda_oe = ~s_nxt.tx[15];
            end else begin
              s_nxt.st     = D_RX;
              s_nxt.sda_oe = 1'b0;
            end
          end
        end
        D_TX: begin
          if (fall) begin
            s_nxt.tx     = {s_r.tx[14:0], 1'b0};
            s_nxt.bitcnt = s_r.bitcnt + 3'h1;
            if (s_r.bitcnt == cci_pkg::CCI_LAST_BIT) begin
              s_nxt.st     = D_MACK;
              s_nxt.sda_oe = 1'b0;
            end else begin
              s_nxt.sda_oe = ~s_r.tx[14];
            end
          end
        end
        D_MACK: begin
          if (rise) begin
            s_nxt.pend = ~s_r.sda_sy[1];
          end else if (fall) begin
            s_nxt.pend   = 1'b0;
            s_nxt.bitcnt = 3'h0;
            if (!s_r.pend) begin
              s_nxt.st = D_IDLE;
            end else if (s_r.idx == cci_pkg::CCI_IDX_DHI) begin
              s_nxt.st     = D_TX;
              s_nxt.idx    = cci_pkg::CCI_IDX_DLO;
              s_nxt.sda_oe = ~s_r.tx[15];
            end else if (cfg[cci_pkg::CCI_CFG_AUTOINC]) begin
              s_nxt.st     = D_TX;
              s_nxt.idx    = cci_pkg::CCI_IDX_DHI;
              s_nxt.addr   = nxt_a;
              s_nxt.tx     = cci_rd(s_r.regs, nxt_a);
              s_nxt.sda_oe = ~s_nxt.tx[15];
            end else begin
              s_nxt.st = D_IDLE;
            end
          end
        end
        default: begin
          s_nxt.st     = D_IDLE;
          s_nxt.sda_oe = 1'b0;
        end
      endcase
    end

    if (soft_reset) begin
      s_nxt.regs                          = '0;
      s_nxt.regs[cci_pkg::CCI_CFG_IDX]    = cci_pkg::CCI_CFG_RST;
      s_nxt.latched                       = 1'b0;
      s_nxt.st                            = D_IDLE;
      s_nxt.sda_oe                        = 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      s_r                           <= '0;
      s_r.st                        <= D_IDLE;
      s_r.regs[cci_pkg::CCI_CFG_IDX] <= cci_pkg::CCI_CFG_RST;
      // Edge detectors start at the idle-high line level, so no false edge follows reset.
      s_r.scl_sy                    <= 2'h3;
      s_r.sda_sy                    <= 2'h3;
      s_r.scl_d                     <= 1'h1;
      s_r.sda_d                     <= 1'h1;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign link.dev_sda_o  = 1'b0;
  assign link.dev_sda_oe = s_r.sda_oe;
  assign link.rb_o       = 1'b0;
  assign link.rb_oe      = s_r.rb_oe;
  assign mode_two_wire   = ~s_r.spi_mode;
  assign strap_free      = s_r.latched;
  assign cfg_word        = s_r.regs[cci_pkg::CCI_CFG_IDX];
  assign reg_wr_stb      = s_r.wr_stb;
  assign reg_wr_addr     = s_r.wr_addr;
  assign reg_wr_data     = s_r.wr_data;
endmodule

// file: verilog/cci_host.sv
/*
  Two-wire bus master for the codec control port, driven through a small
  register file on a plain address/strobe port.
  Assumes a 200 MHz clock; the serial clock is divided from it.
*/
`timescale 1ns/1ps
module cci_host (
  // System
  input  wire logic        clock,
  input  wire logic        reset,
  // Link
  cci_if.host              link,
  // Register port
  input  wire logic [2:0]  bus_addr,
  input  wire logic [15:0] bus_wdata,
  input  wire logic        bus_wr,
  input  wire logic        bus_rd,
  output logic [15:0]      bus_rdata
);
  typedef enum logic [1:0] {
    H_IDLE = 2'b01,
    H_RUN  = 2'b10
  } cci_hst_e;

  typedef struct packed {
    logic [1:0]  sda_sy;
    cci_hst_e    st;
    logic [1:0]  op;
    logic [3:0]  step;
    logic [1:0]  ph;
    logic [7:0]  cnt;
    logic [3:0]  bitn;
    logic [8:0]  sh;
    logic [8:0]  rx;
    logic        scl;
    logic        sda_oe;
    logic [14:0] addr;
    logic [15:0] wdata;
    logic [15:0] rdata;
    logic        nack;
    logic [15:0] rdq;
  } cci_hst_s;

  cci_hst_s s_r;
  cci_hst_s s_nxt;

  // Line action for each step of an operation; any later step is the stop.
  function automatic logic [3:0] cci_act(input logic [1:0] op, input logic [3:0] step);
    cci_act = cci_pkg::CCI_A_STOP;
    case (op)
      cci_pkg::CCI_OP_WRITE: begin
        case (step)
          4'h0: cci_act = cci_pkg::CCI_A_START;
          4'h1: cci_act = cci_pkg::CCI_A_DEV_W;
          4'h2: cci_act = cci_pkg::CCI_A_AHI;
          4'h3: cci_act = cci_pkg::CCI_A_ALO;
          4'h4: cci_act = cci_pkg::CCI_A_DHI;
          4'h5: cci_act = cci_pkg::CCI_A_DLO;
          default: cci_act = cci_pkg::CCI_A_STOP;
        endcase
      end
      cci_pkg::CCI_OP_READ: begin
        case (step)
          4'h0: cci_act = cci_pkg::CCI_A_START;
          4'h1: cci_act = cci_pkg::CCI_A_DEV_W;
          4'h2: cci_act = cci_pkg::CCI_A_AHI;
          4'h3: cci_act = cci_pkg::CCI_A_ALO;
          4'h4: cci_act = cci_pkg::CCI_A_START;
          4'h5: cci_act = cci_pkg::CCI_A_DEV_R;
          4'h6: cci_act = cci_pkg::CCI_A_RX_ACK;
          4'h7: cci_act = cci_pkg::CCI_A_RX_NACK;
          default: cci_act = cci_pkg::CCI_A_STOP;
        endcase
      end
      default: begin
        case (step)
          4'h0: cci_act = cci_pkg::CCI_A_START;
          4'h1: cci_act = cci_pkg::CCI_A_DEV_R;
          4'h2: cci_act = cci_pkg::CCI_A_RX_ACK;
          4'h3: cci_act = cci_pkg::CCI_A_RX_NACK;
          default: cci_act = cci_pkg::CCI_A_STOP;
        endcase
      end
    endcase
  endfunction

  // Nine-bit slot: eight data bits then the acknowledge bit, one means released.
  function automatic logic [8:0] cci_slot(input logic [3:0] a, input logic [14:0] addr,
                                          input logic [15:0] wd);
    case (a)
      cci_pkg::CCI_A_DEV_W:  cci_slot = {cci_pkg::CCI_DEV_ID, 1'b0, 1'b1};
      cci_pkg::CCI_A_DEV_R:  cci_slot = {cci_pkg::CCI_DEV_ID, 1'b1, 1'b1};
      cci_pkg::CCI_A_AHI:    cci_slot = {1'b0, addr[14:8], 1'b1};
      cci_pkg::CCI_A_ALO:    cci_slot = {addr[7:0], 1'b1};
      cci_pkg::CCI_A_DHI:    cci_slot = {wd[15:8], 1'b1};
      cci_pkg::CCI_A_DLO:    cci_slot = {wd[7:0], 1'b1};
      cci_pkg::CCI_A_RX_ACK: cci_slot = 9'h1fe;
      default:               cci_slot = 9'h1ff;
    endcase
  endfunction

  always_comb begin
    logic [3:0] a;
    logic [8:0] cur;
    a   = cci_act(s_r.op, s_r.step);
    cur = (s_r.bitn == 4'h0) ? cci_slot(a, s_r.addr, s_r.wdata) : s_r.sh;

    s_nxt        = s_r;
    s_nxt.sda_sy = {s_r.sda_sy[0], link.sda};
    s_nxt.rdq    = 16'h0000;
    if (bus_rd) begin
      case (bus_addr)
        cci_pkg::CCI_H_CTRL:  s_nxt.rdq = 16'(s_r.op);
        cci_pkg::CCI_H_ADDR:  s_nxt.rdq = 16'(s_r.addr);
        cci_pkg::CCI_H_WDATA: s_nxt.rdq = s_r.wdata;
        cci_pkg::CCI_H_RDATA: s_nxt.rdq = s_r.rdata;
        cci_pkg::CCI_H_STATUS: begin
          s_nxt.rdq[cci_pkg::CCI_ST_BUSY] = (s_r.st == H_RUN);
          s_nxt.rdq[cci_pkg::CCI_ST_NACK] = s_r.nack;
        end
        default: s_nxt.rdq = 16'h0000;
      endcase
    end
    if (bus_wr) begin
      case (bus_addr)
        cci_pkg::CCI_H_ADDR:  s_nxt.addr  = bus_wdata[14:0];
        cci_pkg::CCI_H_WDATA: s_nxt.wdata = bus_wdata;
        cci_pkg::CCI_H_CTRL: begin
          if (s_r.st == H_IDLE) begin
            s_nxt.op   = bus_wdata[1:0];
            s_nxt.st   = H_RUN;
            s_nxt.step = 4'h0;
            s_nxt.ph   = 2'h0;
            s_nxt.cnt  = 8'h00;
            s_nxt.bitn = 4'h0;
            s_nxt.nack = 1'b0;
          end
        end
        default: s_nxt.op = s_r.op;
      endcase
    end

    if (s_r.st == H_RUN) begin
      if (s_r.cnt != cci_pkg::CCI_QUARTER_LAST) begin
        s_nxt.cnt = s_r.cnt + 8'h01;
      end else begin
        s_nxt.cnt = 8'h00;
        s_nxt.ph  = s_r.ph + 2'h1;
        if (a == cci_pkg::CCI_A_START) begin
          // Also serves as repeated start: release, clock high, pull low.
          case (s_r.ph)
            2'h0: s_nxt.sda_oe = 1'b0;
            2'h1: s_nxt.scl = 1'b1;
            2'h2: s_nxt.sda_oe = 1'b1;
            default: begin
              s_nxt.scl  = 1'b0;
              s_nxt.step = s_r.step + 4'h1;
            end
          endcase
        end else if (a == cci_pkg::CCI_A_STOP) begin
          case (s_r.ph)
            2'h0: s_nxt.sda_oe = 1'b1;
            2'h1: s_nxt.scl = 1'b1;
            2'h2: s_nxt.sda_oe = 1'b0;
            default: s_nxt.st = H_IDLE;
          endcase
        end else begin
          case (s_r.ph)
            2'h0: begin
              s_nxt.sh     = cur;
              s_nxt.sda_oe = ~cur[8];
            end
            2'h1: s_nxt.scl = 1'b1;
            2'h2: s_nxt.rx = {s_r.rx[7:0], s_r.sda_sy[1]};
            default: begin
              s_nxt.scl  = 1'b0;
              s_nxt.sh   = {s_r.sh[7:0], 1'b1};
              s_nxt.bitn = s_r.bitn + 4'h1;
              if (s_r.bitn == cci_pkg::CCI_SLOT_BITS) begin
                s_nxt.bitn = 4'h0;
                s_nxt.step = s_r.step + 4'h1;
                if (a == cci_pkg::CCI_A_RX_ACK) begin
                  s_nxt.rdata[15:8] = s_r.rx[8:1];
                end else if (a == cci_pkg::CCI_A_RX_NACK) begin
                  s_nxt.rdata[7:0] = s_r.rx[8:1];
                end else if (s_r.rx[0]) begin
                  s_nxt.nack = 1'b1;
                  s_nxt.step = cci_pkg::CCI_STEP_ABORT;
                end
              end
            end
          endcase
        end
      end
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      s_r     <= '0;
      s_r.st  <= H_IDLE;
      s_r.scl <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign link.scl         = s_r.scl;
  assign link.host_sda_o  = 1'b0;
  assign link.host_sda_oe = s_r.sda_oe;
  assign bus_rdata        = s_r.rdq;
endmodule

// file: test/cci_asserts.sv
/*
  Assertions on the two-wire link between host and device.
  Assumes one clock domain and the signals of cci_if given as plain inputs.
*/
`timescale 1ns/1ps
module cci_asserts (
  // System
  input wire logic clock,
  input wire logic reset,
  // Link
  input wire logic scl,
  input wire logic host_sda_o,
  input wire logic host_sda_oe,
  input wire logic dev_sda_o,
  input wire logic dev_sda_oe,
  input wire logic sda,
  input wire logic strap,
  input wire logic rb_oe
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);
  reset_idle_a: assert property ($fell(reset) |-> scl && !dev_sda_oe && !host_sda_oe && !rb_oe)
    else $error("link not idle after reset");
  dev_od_a: assert property (dev_sda_oe |-> !dev_sda_o && !sda)
    else $error("device drives data high");
  host_od_a: assert property (host_sda_oe |-> !host_sda_o && !sda)
    else $error("host drives data high");
  dev_edge_a: assert property ($changed(dev_sda_oe) |-> !scl)
    else $error("device changed data while clock high");
  dev_hold_a: assert property ($rose(dev_sda_oe) |-> dev_sda_oe[*8])
    else $error("device drive too short");
  scl_low_a: assert property ($fell(scl) |-> !scl[*8])
    else $error("serial clock low phase too short");
  strap_rb_a: assert property (!strap |-> !rb_oe)
    else $error("readback pin driven in two-wire mode");
  start_free_a: assert property (scl && $fell(sda) |-> !dev_sda_oe)
    else $error("device drives at start");
  stop_idle_a: assert property (scl && $rose(sda) |=> !dev_sda_oe[*8])
    else $error("device drives after stop");
  cover property ($rose(dev_sda_oe));
  cover property (scl && $fell(sda));
  cover property (scl && $rose(sda));
endmodule

// file: test/cci_tb_top.sv
/*
  Bench joining host and device over cci_if; transfers are ordered through the host registers.
  Assumes the host register map and timing of cci_pkg and a strap held low.
*/
`timescale 1ns/1ps
module cci_tb_top;
  logic        clock;
  logic        reset;
  logic [2:0]  bus_addr;
  logic [15:0] bus_wdata;
  logic        bus_wr;
  logic        bus_rd;
  logic [15:0] bus_rdata;
  logic        write_only;
  logic        soft_reset;
  logic        mode_two_wire;
  logic        strap_free;
  logic [15:0] cfg_word;
  logic        reg_wr_stb;
  logic [14:0] reg_wr_addr;
  logic [15:0] reg_wr_data;
  logic [15:0] rd_v;
  logic [15:0] cap_a;
  logic [15:0] cap_d;
  int          err_total;
  int          n_tests;
  cci_if link ();
  cci_host i_cci_host (.clock(clock), .reset(reset), .link(link), .bus_addr(bus_addr),
    .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata));
  cci_device i_cci_device (.clock(clock), .reset(reset), .link(link), .soft_reset(soft_reset),
    .write_only(write_only), .mode_two_wire(mode_two_wire), .strap_free(strap_free), .cfg_word(cfg_word),
    .reg_wr_stb(reg_wr_stb), .reg_wr_addr(reg_wr_addr), .reg_wr_data(reg_wr_data));
  cci_asserts i_cci_asserts (.clock(clock), .reset(reset), .scl(link.scl), .host_sda_o(link.host_sda_o),
    .host_sda_oe(link.host_sda_oe), .dev_sda_o(link.dev_sda_o), .dev_sda_oe(link.dev_sda_oe),
    .sda(link.sda), .strap(link.strap), .rb_oe(link.rb_oe));
  // Keeps the last committed write so it can be compared after the transfer ends.
  always @(posedge clock) begin
    if (reg_wr_stb === 1'h1) begin
      cap_a <= {1'h0, reg_wr_addr};
      cap_d <= reg_wr_data;
    end
  end
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wr(input logic [2:0] a, input logic [15:0] d);
    @(posedge clock);
    bus_addr  <= a;
    bus_wdata <= d;
    bus_wr    <= 1'h1;
    @(posedge clock);
    bus_wr <= 1'h0;
  endtask
  task automatic rd(input logic [2:0] a, output logic [15:0] d);
    @(posedge clock);
    bus_addr <= a;
    bus_rd   <= 1'h1;
    @(posedge clock);
    bus_rd <= 1'h0;
    #1 d = bus_rdata;
  endtask
  task automatic xfer(input logic [1:0] op, input logic [14:0] a, input logic [15:0] d);
    int n;
    wr(cci_pkg::CCI_H_ADDR, {1'h0, a});
    wr(cci_pkg::CCI_H_WDATA, d);
    wr(cci_pkg::CCI_H_CTRL, {14'h0, op});
    n = 0;
    rd_v = 16'h1;
    while (rd_v[cci_pkg::CCI_ST_BUSY] !== 1'h0 && n < 20000) begin
      rd(cci_pkg::CCI_H_STATUS, rd_v);
      n++;
    end
    chk("host idle", {15'h0, rd_v[cci_pkg::CCI_ST_BUSY]}, 16'h0);
  endtask
  task automatic close_out;
    $display("checks %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  initial begin
    clock = 1'h0;
    forever #2.5 clock = ~clock;
  end
  initial begin
    #480000;
    err_total++;
    close_out;
  end
  initial begin
    reset = 1'h1;
    bus_addr = 3'h0;
    bus_wdata = 16'h0;
    bus_wr = 1'h0;
    bus_rd = 1'h0;
    write_only = 1'h0;
    link.strap = 1'h0;
    soft_reset = 1'h0;
    err_total = 0;
    n_tests = 0;
    repeat (16) @(posedge clock);
    reset <= 1'h0;
    repeat (10) @(posedge clock);
    chk("cfg_word", cfg_word, 16'h0002);
    chk("mode_two_wire", {15'h0, mode_two_wire}, 16'h1);
    chk("strap_free", {15'h0, strap_free}, 16'h0);
    xfer(cci_pkg::CCI_OP_WRITE, cci_pkg::CCI_CFG_ADDR, 16'ha5cb);
    chk("write ack", {15'h0, rd_v[cci_pkg::CCI_ST_NACK]}, 16'h0);
    chk("write addr", cap_a, 16'h0014);
    chk("write data", cap_d, 16'ha5cb);
    chk("latched cfg_word", cfg_word, 16'ha5cb);
    chk("latched strap_free", {15'h0, strap_free}, 16'h1);
    xfer(cci_pkg::CCI_OP_READ, cci_pkg::CCI_CFG_ADDR, 16'h0);
    rd(cci_pkg::CCI_H_RDATA, rd_v);
    chk("read data", rd_v, 16'ha5cb);
    xfer(cci_pkg::CCI_OP_READ_LAST, 15'h0, 16'h0);
    rd(cci_pkg::CCI_H_RDATA, rd_v);
    chk("read last data", rd_v, 16'ha5cb);
    write_only <= 1'h1;
    xfer(cci_pkg::CCI_OP_READ, cci_pkg::CCI_CFG_ADDR, 16'h0);
    chk("refused read", {15'h0, rd_v[cci_pkg::CCI_ST_NACK]}, 16'h1);
    @(posedge clock);
    soft_reset <= 1'h1;
    @(posedge clock);
    soft_reset <= 1'h0;
    repeat (2) @(posedge clock);
    chk("soft reset cfg_word", cfg_word, 16'h0002);
    chk("soft reset strap_free", {15'h0, strap_free}, 16'h0);
    close_out;
  end
endmodule
